// >>> ftom_pkg.sv
// constants shared by the fan tach overflow monitor
package ftom_pkg;
    localparam int          REF_CLK_MHZ       = 200;
    // one count per 50 us: 1,200,000 counts per minute at divisor 1
    localparam int          COUNT_NUMERATOR   = 1200000;
    localparam int          SECONDS_PER_MIN   = 60;
    localparam int          COUNT_PERIOD_NS   =
        1000000000 / (COUNT_NUMERATOR / SECONDS_PER_MIN);
    localparam int          BASE_TICK_CYCLES  =
        COUNT_PERIOD_NS * REF_CLK_MHZ / 1000;
    localparam int          ADDR_W            = 10;
    localparam int          DATA_W            = 32;
    localparam int          CNT_W             = 8;
    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_CONTROL       = 8'h3c;
    localparam logic [7:0]  IDX_THRESHOLD     = 8'h3d;
    localparam logic [7:0]  IDX_CUR_COUNT     = 8'h3e;
    localparam logic [7:0]  IDX_STATUS        = 8'h3f;
    // control field positions
    localparam int          CTL_MON_EN_BIT    = 0;
    localparam int          CTL_IRQ_EN_BIT    = 1;
    localparam int          CTL_DIV_LSB       = 2;
    localparam int          DIV_SEL_W         = 2;
    localparam int          STS_FAIL_BIT      = 0;
    localparam logic [7:0]  THRESHOLD_RESET   = 8'h00;
    localparam logic [7:0]  CONTROL_RESET     = 8'h00;
    localparam logic [7:0]  COUNT_MAX         = 8'hff;
    localparam logic [7:0]  COUNT_ZERO        = 8'h00;
endpackage

// >>> ftom_rate_tick.sv
// count-rate tick generator: base period scaled by 1, 2, 4 or 8
`timescale 1ns/1ps
module ftom_rate_tick import ftom_pkg::*; #(
    parameter int BASE_CYCLES = BASE_TICK_CYCLES
) (
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    input  wire logic                 restart,
    input  wire logic [DIV_SEL_W-1:0] div_sel,
    output logic                      tick
);
    localparam int BASE_W = $clog2(BASE_CYCLES + 1);
    localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(BASE_CYCLES - 1);

    logic [BASE_W-1:0] base_q;
    logic [2:0]        div_q;
    wire               base_end = (base_q == BASE_LAST);
    // divisor is 2**div_sel: codes 00,01,10,11 give 1,2,4,8
    wire  [2:0]        div_last = 3'((4'h1 << div_sel) - 4'h1);

    assign tick = base_end && (div_q == div_last);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            base_q <= '0;
            div_q  <= 3'h0;
        end else if (restart) begin
            base_q <= '0;
            div_q  <= 3'h0;
        end else begin
            base_q <= base_end ? '0 : base_q + BASE_W'(1);
            if (base_end)
                div_q <= (div_q == div_last) ? 3'h0 : div_q + 3'h1;
        end
    end
endmodule // ftom_rate_tick

// >>> ftom_monitor.sv
// fan tach overflow monitor for the fourth fan channel, avalon-mm slave
//
// Overview of operation
// - raise interrupt when 8-bit speed counter exceeds threshold
// - failure means counter above stored value; equality does not trigger
// - count per revolution is 1,200,000 over rpm times divisor
// - divisor code 11 selects divide by 8, 150 counts at 1000 rpm
// - threshold is 8-bit read/write register at index 3dh
// - divisor codes 00, 01, 10 select divide by 1, 2, 4
// - interrupt mode holds current count until cleared; clearing zeroes it
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
module ftom_monitor import ftom_pkg::*; #(
    parameter int BASE_CYCLES = BASE_TICK_CYCLES
) (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [DATA_W-1:0]      avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              fan3_tach_pin,
    output logic                   fan_fail_irq
);
    logic [7:0]        fan3_speed_fail_threshold_q;
    logic [7:0]        fan3_speed_control_q;
    logic [7:0]        cur_count_q;
    logic [7:0]        speed_cnt_q;
    logic              measuring_q;
    logic              fail_q;
    logic              tach_prev_q;
    logic              ack_q;
    logic [DATA_W-1:0] rdata_q;
    logic              tick;

    // bus decode; one wait state, answer at the second edge
    wire       req       = avs_read || avs_write;
    wire       take      = req && !ack_q;
    wire [7:0] idx       = avs_address[ADDR_W-1:2];
    wire       word_ok   = (avs_address[1:0] == 2'b00);
    wire       lane0_wr  = avs_write && take && word_ok && avs_byteenable[0];
    wire       wr_ctl    = lane0_wr && (idx == IDX_CONTROL);
    wire       wr_thr    = lane0_wr && (idx == IDX_THRESHOLD);
    wire       wr_sts    = lane0_wr && (idx == IDX_STATUS);
    wire       fail_clr  = wr_sts && avs_writedata[STS_FAIL_BIT];

    wire       speed_monitor_enable = fan3_speed_control_q[CTL_MON_EN_BIT];
    wire       speed_irq_enable     = fan3_speed_control_q[CTL_IRQ_EN_BIT];
    wire [DIV_SEL_W-1:0] div_sel    =
        fan3_speed_control_q[CTL_DIV_LSB +: DIV_SEL_W];

    wire       tach_rise = fan3_tach_pin && !tach_prev_q;
    // strict compare: equality is still a healthy fan
    wire       over      = measuring_q &&
                           (speed_cnt_q > fan3_speed_fail_threshold_q);
    // only a fresh crossing sets; a stale frozen count must not block clear
    wire       fail_set  = speed_monitor_enable && speed_irq_enable &&
                           over && !fail_q;
    // frozen while an interrupt is pending in interrupt mode
    wire       frozen    = speed_irq_enable && fail_q;
    wire       restart   = !speed_monitor_enable || tach_rise || fail_clr;
    wire       cnt_sat   = (speed_cnt_q == COUNT_MAX);

    wire [7:0] rd_mux =
        !word_ok                 ? COUNT_ZERO :
        (idx == IDX_CONTROL)     ? fan3_speed_control_q :
        (idx == IDX_THRESHOLD)   ? fan3_speed_fail_threshold_q :
        (idx == IDX_CUR_COUNT)   ? cur_count_q :
        (idx == IDX_STATUS)      ? {7'h00, fail_q} : COUNT_ZERO;

    assign avs_waitrequest = req && !ack_q;
    assign avs_readdata    = rdata_q;
    assign fan_fail_irq    = fail_q;

    ftom_rate_tick #(
        .BASE_CYCLES (BASE_CYCLES)
    ) u_rate (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .restart (restart),
        .div_sel (div_sel),
        .tick    (tick)
    );

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_q   <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= take;
            if (take && avs_read)
                rdata_q <= {24'h000000, rd_mux};
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fan3_speed_fail_threshold_q <= THRESHOLD_RESET;
            fan3_speed_control_q        <= CONTROL_RESET;
        end else begin
            if (wr_thr)
                fan3_speed_fail_threshold_q <= avs_writedata[7:0];
            if (wr_ctl)
                fan3_speed_control_q <= avs_writedata[7:0];
        end
    end

    // tach is taken as synchronous; one pulse per revolution
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            tach_prev_q <= 1'b0;
        else
            tach_prev_q <= fan3_tach_pin;
    end

    // a revolution is only valid once a first edge opened the window
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            measuring_q <= 1'b0;
        else if (!speed_monitor_enable || fail_clr)
            measuring_q <= 1'b0;
        else if (tach_rise)
            measuring_q <= 1'b1;
    end

    // saturating so a stalled fan stays above threshold
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            speed_cnt_q <= COUNT_ZERO;
        else if (restart)
            speed_cnt_q <= COUNT_ZERO;
        else if (tick && measuring_q && !frozen && !cnt_sat)
            speed_cnt_q <= speed_cnt_q + 8'h01;
    end

    // once per revolution, or the failing value at interrupt time
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            cur_count_q <= COUNT_ZERO;
        else if (!speed_monitor_enable || fail_clr)
            cur_count_q <= COUNT_ZERO;
        else if (frozen)
            cur_count_q <= cur_count_q;
        else if (fail_set)
            cur_count_q <= speed_cnt_q;
        else if (tach_rise && measuring_q)
            cur_count_q <= speed_cnt_q;
    end

    // sticky; a new failure in the clear cycle wins
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            fail_q <= 1'b0;
        else if (fail_set)
            fail_q <= 1'b1;
        else if (fail_clr)
            fail_q <= 1'b0;
    end
endmodule // ftom_monitor

// >>> ftom_tach_model.sv
// fan tachometer model: one pulse per revolution
`timescale 1ns/1ps
module ftom_tach_model (
    input  wire logic        ref_clk,
    input  wire logic [15:0] period,
    output logic             tach = 1'b0
);
    logic [15:0] cnt_q = 16'h0;
    // period 0 is a stalled fan, line parked low
    always_ff @(posedge ref_clk) begin
        cnt_q <= (cnt_q + 16'h1 >= period) ? 16'h0 : cnt_q + 16'h1;
        tach  <= (period != 16'h0) && (cnt_q < (period >> 1));
    end
endmodule // ftom_tach_model

// >>> ftom_monitor_chk.sv
// port assertions for the fan tach overflow monitor
`timescale 1ns/1ps
module ftom_monitor_chk import ftom_pkg::*; (
    input wire logic              ref_clk,
    input wire logic              reset_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [3:0]        avs_byteenable,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic              avs_waitrequest,
    input wire logic              fan_fail_irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    wire req = avs_read | avs_write;
    wire rd1 = avs_read & avs_waitrequest;
    wire clr = avs_write & avs_waitrequest & avs_writedata[0]
        & avs_byteenable[0] & (avs_address == {IDX_STATUS, 2'b00});
    sequence one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    a_wait_one: assert property (req && avs_waitrequest |-> one_wait)
        else $error("more than one wait state");
    a_wait_first: assert property (req && !$past(req)
        |-> avs_waitrequest)
        else $error("no wait state on new request");
    a_wait_idle: assert property (!req |-> !avs_waitrequest)
        else $error("waitrequest while idle");
    a_data_stable: assert property (!rd1 |=> $stable(avs_readdata))
        else $error("readdata moved without a read");
    a_bad_addr: assert property (rd1 && (avs_address[9:4] != 6'h0f
        || avs_address[1:0] != 2'h0) |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_status_read: assert property (rd1 && avs_address == 10'h0fc
        |=> avs_readdata[0] == $past(fan_fail_irq))
        else $error("status bit differs from irq");
    // a fresh failure in the clear cycle wins, so only a set flag must drop
    a_irq_clear: assert property (clr && fan_fail_irq
        |=> !fan_fail_irq)
        else $error("irq not cleared");
    a_irq_hold: assert property (fan_fail_irq && !clr
        |=> fan_fail_irq)
        else $error("irq dropped without clear");
endmodule // ftom_monitor_chk
bind ftom_monitor ftom_monitor_chk u_chk (.ref_clk, .reset_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .fan_fail_irq);

// >>> tb_ftom_monitor.sv
// self-checking bench for the fan tach overflow monitor
`timescale 1ns/1ps
module tb_ftom_monitor import ftom_pkg::*;;
    logic              ref_clk = 1'b0, reset_n = 1'b0;
    logic              avs_read = 1'b0, avs_write = 1'b0;
    logic [ADDR_W-1:0] avs_address = 10'h0;
    logic [DATA_W-1:0] avs_writedata = 32'h0, avs_readdata;
    logic              avs_waitrequest, fan3_tach_pin, fan_fail_irq;
    logic [15:0]       period = 16'h0;
    int                bad_count = 0, tests_run = 0, cyc = 0;
    // short base tick keeps revolutions to a few thousand cycles
    ftom_monitor #(.BASE_CYCLES(4)) dut (.ref_clk, .reset_n, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'h1),
        .avs_readdata, .avs_waitrequest, .fan3_tach_pin, .fan_fail_irq);
    ftom_tach_model fan (.ref_clk, .period, .tach(fan3_tach_pin));
    initial forever #2.5 ref_clk = ~ref_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] idx,
        input logic [7:0] d);
        @(posedge ref_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_read <= ~w;
        avs_write <= w;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h0);
        check(avs_readdata, exp);
    endtask
    task automatic run(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic complete_run;
        if (bad_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            bad_count++;
            complete_run;
        end
    end
    initial begin
        run(20);
        reset_n <= 1'b1;
        rchk(IDX_THRESHOLD, 32'h0);
        bus(1'b1, IDX_THRESHOLD, 8'ha5);
        rchk(IDX_THRESHOLD, 32'ha5);
        rchk(8'h3b, 32'h0);
        // half a tick over 150 so phase slips cannot change the count
        for (int d = 0; d < 4; d++) begin
            period <= 16'd602 << d;
            bus(1'b1, IDX_CONTROL, 8'(d << 2) | 8'h01);
            run(32'(period) * 2 + 20);
            rchk(IDX_CUR_COUNT, 32'h96);
        end
        bus(1'b1, IDX_THRESHOLD, 8'h96);
        bus(1'b1, IDX_CONTROL, 8'h0f);
        run(9700);
        check(fan_fail_irq, 1'b0);
        bus(1'b1, IDX_THRESHOLD, 8'h95);
        run(4900);
        check(fan_fail_irq, 1'b1);
        run(4816);
        rchk(IDX_CUR_COUNT, 32'h96);
        rchk(IDX_STATUS, 32'h1);
        bus(1'b1, IDX_STATUS, 8'h01);
        check(fan_fail_irq, 1'b0);
        rchk(IDX_CUR_COUNT, 32'h0);
        bus(1'b1, IDX_CONTROL, 8'h0d);
        period <= 16'd9000;
        run(18020);
        rchk(IDX_CUR_COUNT, 32'hff);
        check(fan_fail_irq, 1'b0);
        complete_run;
    end
endmodule // tb_ftom_monitor
